// ---- hw/front_panel_control_status.sv ----
// Front-panel button editing, indicator drive and APB settings for an
// audio embedder and extractor. Assumes buttons, levels and NV storage
// signals are synchronous to pclk and buttons are already debounced.
`timescale 1ns/1ps
`default_nettype none
`include "front_panel_cfg.svh"

module front_panel_control_status
   import front_panel_pkg::*;
#(
   parameter int unsigned COMMIT_CYCLES = `COMMIT_CYCLES_DFLT,
   parameter int unsigned BLINK_CYCLES = `BLINK_CYCLES_DFLT,
   parameter int unsigned SAMPLE_W = `SAMPLE_W
) (
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // APB slave.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [`ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Buttons, high while pressed.
   input wire logic btn_edit,
   input wire logic btn_right,
   input wire logic btn_left,
   // Status from the video and audio path.
   input wire logic sdi_valid,
   input wire logic [`NUM_GROUPS-1:0] group_audio,
   input wire logic [`AES_PORTS-1:0][SAMPLE_W-1:0] pair_peak,
   input wire logic power_ok,
   // Non-volatile storage.
   input wire logic [1:0] nv_rd_mode,
   input wire logic [1:0] nv_rd_group,
   input wire logic [31:0] nv_rd_gain,
   output logic nv_wr_stb,
   output logic [1:0] nv_wr_mode,
   output logic [1:0] nv_wr_group,
   output logic [31:0] nv_wr_gain,
   // Indicators.
   output logic led_input,
   output logic led_mode_embed,
   output logic led_mode_extract,
   output logic [`NUM_GROUPS-1:0] led_group_green,
   output logic [`NUM_GROUPS-1:0] led_group_red,
   output logic [`AES_PORTS-1:0] led_vu_red,
   output logic [`AES_PORTS-1:0] led_vu_green,
   output logic [`AES_PORTS-1:0] led_gain_red,
   // Settings for the audio path.
   output logic [`AES_PORTS-1:0] aes_port_out,
   output logic video_keep_audio,
   output logic [1:0] op_mode,
   output logic [1:0] group_sel,
   output logic [31:0] pair_gain,
   output logic ref_is_18,
   output logic [2:0] headroom_sel,
   output logic [9:0] audio_delay_ms
);

   ////////////////////////////////////////////////////////////////////////////

   panel_state_t s_q;
   panel_state_t s_d;
   level_color_t vu_color [`AES_PORTS];

   localparam logic [`COMMIT_CNT_W-1:0] COMMIT_LOAD = `COMMIT_CNT_W'(COMMIT_CYCLES - 1);
   localparam logic [`BLINK_CNT_W-1:0] BLINK_LAST = `BLINK_CNT_W'(BLINK_CYCLES - 1);

   // Address decode shared by reads and writes.
   function automatic logic reg_hit(input logic [`ADDR_W-1:0] a);
      reg_hit = (a == `REG_CTRL) || (a == `REG_DELAY) || (a == `REG_GAIN) || (a == `REG_STATUS);
   endfunction : reg_hit

   // One dB step of a pair gain, held inside the documented range.
   function automatic logic [7:0] step_gain(input logic [7:0] g, input logic up);
      logic signed [7:0] v;
      v = $signed(g);
      if (up && v < `GAIN_MAX) begin
         step_gain = 8'(v + 8'sh01);
      end else if (!up && v > `GAIN_MIN) begin
         step_gain = 8'(v - 8'sh01);
      end else begin
         step_gain = g;
      end
   endfunction : step_gain

   function automatic logic [7:0] clamp_gain(input logic [7:0] g);
      logic signed [7:0] v;
      v = $signed(g);
      if (v > `GAIN_MAX) begin
         clamp_gain = `GAIN_MAX;
      end else if (v < `GAIN_MIN) begin
         clamp_gain = `GAIN_MIN;
      end else begin
         clamp_gain = g;
      end
   endfunction : clamp_gain

   ////////////////////////////////////////////////////////////////////////////

   for (genvar p = 0; p < `AES_PORTS; p++) begin : g_meter
      level_meter #(
         .SAMPLE_W(SAMPLE_W)
      ) u_meter (
         .peak(pair_peak[p]),
         .ref18(s_q.ref18),
         .headroom(s_q.headroom),
         .color(vu_color[p])
      );
   end

   ////////////////////////////////////////////////////////////////////////////

   logic press_edit;
   logic press_right;
   logic press_left;
   logic arrow;
   logic apb_done;
   logic apb_wr;
   logic [31:0] rd;
   logic blink_edit;

   always_comb begin
      s_d = s_q;
      s_d.nv_wr = 1'b0;
      s_d.pready = 1'b0;
      s_d.pslverr = 1'b0;
      press_edit = btn_edit && !s_q.btn_prev[0];
      press_right = btn_right && !s_q.btn_prev[1];
      press_left = btn_left && !s_q.btn_prev[2];
      arrow = press_right || press_left;
      s_d.btn_prev = {btn_left, btn_right, btn_edit};

      // The stored settings take effect once after each reset, so a
      // value left pending at power loss is simply never seen again.
      if (!s_q.loaded) begin
         s_d.loaded = 1'b1;
         s_d.mode = (nv_rd_mode == MODE_EXTRACT || nv_rd_mode == MODE_EMBED_CASCADE) ?
                    op_mode_t'(nv_rd_mode) : MODE_EMBED_REPLACE;
         s_d.group = nv_rd_group;
         for (int i = 0; i < `AES_PORTS; i++) begin
            s_d.gain[i] = clamp_gain(nv_rd_gain[8*i +: 8]);
         end
      end

      // Blink enable from a divider.
      if (s_q.blink_cnt == BLINK_LAST) begin
         s_d.blink_cnt = '0;
         s_d.blink_on = !s_q.blink_on;
      end else begin
         s_d.blink_cnt = s_q.blink_cnt + 1'b1;
      end

      if (s_q.pending) begin
         if (s_q.commit_cnt == '0) begin
            s_d.pending = 1'b0;
            s_d.edited = EDIT_NONE;
            s_d.nv_wr = 1'b1;
            s_d.nv_mode = s_q.mode;
            s_d.nv_group = s_q.group;
            s_d.nv_gain = s_q.gain;
         end else begin
            s_d.commit_cnt = s_q.commit_cnt - 1'b1;
         end
      end

      if (press_edit) begin
         unique case (s_q.section)
            SEC_IDLE: s_d.section = SEC_MODE;
            SEC_MODE: s_d.section = SEC_GROUP;
            SEC_GROUP: s_d.section = SEC_PAIR;
            SEC_PAIR: s_d.section = SEC_GAIN;
            SEC_GAIN: s_d.section = SEC_IDLE;
            default: s_d.section = SEC_IDLE;
         endcase
      end else if (arrow && s_q.loaded) begin
         unique case (s_q.section)
            SEC_IDLE: begin
            end
            SEC_MODE: begin
               unique case (s_q.mode)
                  MODE_EMBED_REPLACE: s_d.mode = press_right ? MODE_EMBED_CASCADE : MODE_EXTRACT;
                  MODE_EMBED_CASCADE: s_d.mode = press_right ? MODE_EXTRACT : MODE_EMBED_REPLACE;
                  MODE_EXTRACT: s_d.mode = press_right ? MODE_EMBED_REPLACE : MODE_EMBED_CASCADE;
                  default: s_d.mode = MODE_EMBED_REPLACE;
               endcase
               s_d.edited = EDIT_MODE;
            end
            SEC_GROUP: begin
               s_d.group = press_right ? s_q.group + 1'b1 : s_q.group - 1'b1;
               s_d.edited = EDIT_GROUP;
            end
            SEC_PAIR: begin
               s_d.pair_sel = press_right ? s_q.pair_sel + 1'b1 : s_q.pair_sel - 1'b1;
            end
            SEC_GAIN: begin
               s_d.gain[s_q.pair_sel] = step_gain(s_q.gain[s_q.pair_sel], press_right);
               s_d.edited = EDIT_GAIN;
               s_d.edited_pair = s_q.pair_sel;
            end
            default: s_d.section = SEC_IDLE;
         endcase
         if (s_q.section != SEC_IDLE && s_q.section != SEC_PAIR) begin
            s_d.pending = 1'b1;
            s_d.commit_cnt = COMMIT_LOAD;
         end
      end

      // APB: one wait state, so the read word is already registered when
      // pready rises, and the write lands on the next edge, which ends the transfer.
      apb_done = psel && penable && s_q.pready;
      apb_wr = apb_done && pwrite && reg_hit(paddr);
      rd = '0;
      unique case (paddr)
         `REG_CTRL: begin
            rd[`CTRL_MODE_LSB +: 2] = s_q.mode;
            rd[`CTRL_GROUP_LSB +: 2] = s_q.group;
            rd[`CTRL_REF18_BIT] = s_q.ref18;
            rd[`CTRL_HDRM_LSB +: 3] = s_q.headroom;
         end
         `REG_DELAY: rd[9:0] = s_q.delay_ms;
         `REG_GAIN: rd = s_q.gain;
         `REG_STATUS: begin
            rd[`STAT_INPUT_BIT] = sdi_valid;
            rd[`STAT_GRP_AUDIO_BIT] = group_audio[s_q.group];
            rd[`STAT_PENDING_BIT] = s_q.pending;
            rd[`STAT_SECTION_LSB +: 3] = s_q.section;
            rd[`STAT_PAIR_LSB +: 2] = s_q.pair_sel;
            rd[`STAT_LOADED_BIT] = s_q.loaded;
         end
         default: rd = '0;
      endcase
      if (psel && penable && !s_q.pready) begin
         s_d.pready = 1'b1;
         s_d.pslverr = !reg_hit(paddr);
         s_d.prdata = pwrite ? '0 : rd;
      end
      if (apb_wr) begin
         unique case (paddr)
            `REG_CTRL: begin
               if (pwdata[`CTRL_MODE_LSB +: 2] == MODE_EXTRACT ||
                   pwdata[`CTRL_MODE_LSB +: 2] == MODE_EMBED_CASCADE) begin
                  s_d.mode = op_mode_t'(pwdata[`CTRL_MODE_LSB +: 2]);
               end else begin
                  s_d.mode = MODE_EMBED_REPLACE;
               end
               s_d.group = pwdata[`CTRL_GROUP_LSB +: 2];
               s_d.ref18 = pwdata[`CTRL_REF18_BIT];
               s_d.headroom = (pwdata[`CTRL_HDRM_LSB +: 3] > `HEADROOM_MAX) ?
                              `HEADROOM_MAX : pwdata[`CTRL_HDRM_LSB +: 3];
               s_d.edited = EDIT_MODE;
            end
            `REG_DELAY: begin
               s_d.delay_ms = (pwdata[15:0] > `DELAY_MAX_MS) ? 10'(`DELAY_MAX_MS) : pwdata[9:0];
            end
            `REG_GAIN: begin
               for (int i = 0; i < `AES_PORTS; i++) begin
                  s_d.gain[i] = clamp_gain(pwdata[8*i +: 8]);
               end
               s_d.edited = EDIT_GAIN;
            end
            default: begin
            end
         endcase
         if (paddr == `REG_CTRL || paddr == `REG_GAIN) begin
            s_d.pending = 1'b1;
            s_d.commit_cnt = COMMIT_LOAD;
         end
      end

      if (!power_ok) begin
         s_d.pending = 1'b0;
         s_d.edited = EDIT_NONE;
         s_d.nv_wr = 1'b0;
      end

      // Indicators, registered one cycle after their cause.
      blink_edit = s_q.pending && s_q.blink_on;
      s_d.led_in = sdi_valid;
      s_d.led_embed = (s_q.mode != MODE_EXTRACT) && !(blink_edit && s_q.edited == EDIT_MODE);
      s_d.led_extract = (s_q.mode == MODE_EXTRACT) && !(blink_edit && s_q.edited == EDIT_MODE);
      for (int g = 0; g < `NUM_GROUPS; g++) begin
         s_d.grp_green[g] = (s_q.group == 2'(g)) && group_audio[g] &&
                            !(blink_edit && s_q.edited == EDIT_GROUP);
         s_d.grp_red[g] = (s_q.group == 2'(g)) && !group_audio[g] &&
                          !(blink_edit && s_q.edited == EDIT_GROUP);
      end
      for (int p = 0; p < `AES_PORTS; p++) begin
         // Orange shows as red and green together.
         s_d.vu_red[p] = (vu_color[p] == LVL_RED) || (vu_color[p] == LVL_ORANGE);
         s_d.vu_green[p] = (vu_color[p] == LVL_GREEN) || (vu_color[p] == LVL_ORANGE);
         s_d.gain_red[p] = (s_q.gain[p] != `GAIN_UNITY) &&
                           !(blink_edit && s_q.edited == EDIT_GAIN && s_q.edited_pair == 2'(p));
         s_d.aes_out[p] = (s_q.mode == MODE_EXTRACT);
      end
      s_d.keep_audio = (s_q.mode == MODE_EXTRACT);
   end

   ////////////////////////////////////////////////////////////////////////////

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= '0;
         s_q.mode <= MODE_EMBED_REPLACE;
         s_q.group <= `RST_GROUP;
         s_q.gain <= `RST_GAIN;
         s_q.headroom <= `RST_HEADROOM;
         s_q.delay_ms <= `RST_DELAY;
         s_q.section <= SEC_IDLE;
         s_q.edited <= EDIT_NONE;
         s_q.nv_mode <= MODE_EMBED_REPLACE;
      end else begin
         s_q <= s_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////

   assign prdata = s_q.prdata;
   assign pready = s_q.pready;
   assign pslverr = s_q.pslverr;
   assign nv_wr_stb = s_q.nv_wr;
   assign nv_wr_mode = s_q.nv_mode;
   assign nv_wr_group = s_q.nv_group;
   assign nv_wr_gain = s_q.nv_gain;
   assign led_input = s_q.led_in;
   assign led_mode_embed = s_q.led_embed;
   assign led_mode_extract = s_q.led_extract;
   assign led_group_green = s_q.grp_green;
   assign led_group_red = s_q.grp_red;
   assign led_vu_red = s_q.vu_red;
   assign led_vu_green = s_q.vu_green;
   assign led_gain_red = s_q.gain_red;
   assign aes_port_out = s_q.aes_out;
   assign video_keep_audio = s_q.keep_audio;
   assign op_mode = s_q.mode;
   assign group_sel = s_q.group;
   assign pair_gain = s_q.gain;
   assign ref_is_18 = s_q.ref18;
   assign headroom_sel = s_q.headroom;
   assign audio_delay_ms = s_q.delay_ms;

endmodule : front_panel_control_status
`default_nettype wire

// ---- hw/front_panel_cfg.svh ----
// Constants for the front-panel control and status block.
// Assumes a 50 MHz system clock and an APB register bus.
`ifndef FRONT_PANEL_CFG_SVH
`define FRONT_PANEL_CFG_SVH

// Clock and timing.
`define CLK_HZ 50000000
`define COMMIT_TIME_S 15
`define COMMIT_CYCLES_DFLT (`COMMIT_TIME_S * `CLK_HZ)
`define BLINK_TIME_MS 250
`define BLINK_CYCLES_DFLT (`BLINK_TIME_MS * (`CLK_HZ / 1000))
`define COMMIT_CNT_W 30
`define BLINK_CNT_W 24

// Audio and ports.
`define SAMPLE_W 24
`define AES_PORTS 4
`define CH_PER_PORT 2
`define NUM_GROUPS 4

// Metering in dB.
`define REF_LOW_DBFS (-20)
`define REF_HIGH_DBFS (-18)
`define VU_GREEN_SPAN_DB 20
`define DB_PER_BIT 6
`define HEADROOM_STEP_DB 2
`define HEADROOM_CLIP 3'h0
`define HEADROOM_MAX 3'h5

// Gain limits in dB, unity is zero, and the delay limit in ms.
`define GAIN_MAX 8'sh0c
`define GAIN_MIN (-8'sh46)
`define GAIN_UNITY 8'h00
`define DELAY_MAX_MS 16'h03e8

// Register map, byte addresses.
`define ADDR_W 12
`define REG_CTRL 12'h000
`define REG_DELAY 12'h004
`define REG_GAIN 12'h008
`define REG_STATUS 12'h00c

// CTRL fields.
`define CTRL_MODE_LSB 0
`define CTRL_GROUP_LSB 2
`define CTRL_REF18_BIT 4
`define CTRL_HDRM_LSB 5

// STATUS fields.
`define STAT_INPUT_BIT 0
`define STAT_GRP_AUDIO_BIT 1
`define STAT_PENDING_BIT 2
`define STAT_SECTION_LSB 3
`define STAT_PAIR_LSB 6
`define STAT_LOADED_BIT 8

// Reset values.
`define RST_GROUP 2'h0
`define RST_GAIN 32'h0000_0000
`define RST_HEADROOM 3'h0
`define RST_DELAY 10'h000

`endif

// ---- hw/front_panel_pkg.sv ----
// Types shared by the front-panel control and status design.
// Field widths are written out here and must match front_panel_cfg.svh.
package front_panel_pkg;

   typedef enum logic [1:0] {
      MODE_EMBED_REPLACE = 2'b00,
      MODE_EMBED_CASCADE = 2'b01,
      MODE_EXTRACT = 2'b10
   } op_mode_t;

   typedef enum logic [2:0] {
      SEC_IDLE = 3'b000,
      SEC_MODE = 3'b001,
      SEC_GROUP = 3'b010,
      SEC_PAIR = 3'b011,
      SEC_GAIN = 3'b100
   } section_t;

   typedef enum logic [1:0] {
      LVL_OFF = 2'b00,
      LVL_GREEN = 2'b01,
      LVL_ORANGE = 2'b10,
      LVL_RED = 2'b11
   } level_color_t;

   typedef enum logic [1:0] {
      EDIT_NONE = 2'b00,
      EDIT_MODE = 2'b01,
      EDIT_GROUP = 2'b10,
      EDIT_GAIN = 2'b11
   } edit_t;

   typedef struct packed {
      op_mode_t mode;
      logic [1:0] group;
      logic [3:0][7:0] gain;
      logic ref18;
      logic [2:0] headroom;
      logic [9:0] delay_ms;
      section_t section;
      logic [1:0] pair_sel;
      logic [2:0] btn_prev;
      logic loaded;
      logic pending;
      edit_t edited;
      logic [1:0] edited_pair;
      logic [29:0] commit_cnt;
      logic [23:0] blink_cnt;
      logic blink_on;
      logic nv_wr;
      op_mode_t nv_mode;
      logic [1:0] nv_group;
      logic [31:0] nv_gain;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
      logic led_in;
      logic led_embed;
      logic led_extract;
      logic [3:0] grp_green;
      logic [3:0] grp_red;
      logic [3:0] vu_red;
      logic [3:0] vu_green;
      logic [3:0] gain_red;
      logic [3:0] aes_out;
      logic keep_audio;
   } panel_state_t;

endpackage : front_panel_pkg

// ---- hw/level_meter.sv ----
// Peak-to-colour converter for one channel pair.
// Assumes peak is the unsigned magnitude of the loudest recent sample.
`timescale 1ns/1ps
`default_nettype none
`include "front_panel_cfg.svh"

module level_meter
   import front_panel_pkg::*;
#(
   parameter int unsigned SAMPLE_W = `SAMPLE_W
) (
   // Level in.
   input wire logic [SAMPLE_W-1:0] peak,
   // Settings.
   input wire logic ref18,
   input wire logic [2:0] headroom,
   // Colour out.
   output level_color_t color
);

   int lz;
   int db;
   int ref_db;
   logic red;

   always_comb begin
      // Six dB per bit is coarse but needs no lookup table.
      lz = SAMPLE_W;
      for (int i = 0; i < SAMPLE_W; i++) begin
         if (peak[i]) begin
            lz = SAMPLE_W - 1 - i;
         end
      end
      db = -(`DB_PER_BIT * lz);
      ref_db = ref18 ? `REF_HIGH_DBFS : `REF_LOW_DBFS;
      if (headroom == `HEADROOM_CLIP) begin
         red = (lz == 0);
      end else begin
         red = db > -(`HEADROOM_STEP_DB * int'(headroom));
      end
      if (red) begin
         color = LVL_RED;
      end else if (db > ref_db) begin
         color = LVL_ORANGE;
      end else if (db > ref_db - `VU_GREEN_SPAN_DB) begin
         color = LVL_GREEN;
      end else begin
         color = LVL_OFF;
      end
   end

endmodule : level_meter
`default_nettype wire

// ---- testbench/panel_properties.sv ----
// Concurrent checks on the front-panel block, seen from its top ports.
// Assumes one pclk domain with presetn low active and a bind below.
`timescale 1ns/1ps
`default_nettype none
module panel_checker #(
   parameter int unsigned COMMIT_CYCLES = 50,
   parameter int unsigned BLINK_CYCLES = 4
) (
   // Clock, reset and bus.
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   // Status and storage.
   input wire logic sdi_valid,
   input wire logic led_input,
   input wire logic power_ok,
   input wire logic nv_wr_stb,
   input wire logic [1:0] nv_wr_mode,
   input wire logic [1:0] nv_wr_group,
   input wire logic [31:0] nv_wr_gain,
   // Settings and indicators.
   input wire logic [1:0] op_mode,
   input wire logic [1:0] group_sel,
   input wire logic [31:0] pair_gain,
   input wire logic [3:0] aes_port_out,
   input wire logic video_keep_audio,
   input wire logic [3:0] led_group_green,
   input wire logic [3:0] led_group_red,
   input wire logic [3:0] led_gain_red
);
   logic [1:0] age_q;
   logic [35:0] prev_q;
   logic [31:0] quiet_q;
   logic [31:0] dark_q;
   wire logic old = age_q == 2'h3;
   wire logic [3:0] nz = {|pair_gain[31:24], |pair_gain[23:16], |pair_gain[15:8], |pair_gain[7:0]};
   wire logic [3:0] lit = (led_group_green | led_group_red) & ~(4'h1 << group_sel);
   // Settings age, and how long a due gain LED is held dark.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         age_q <= 2'h0;
         prev_q <= '0;
         quiet_q <= '0;
         dark_q <= '0;
      end else begin
         age_q <= old ? age_q : age_q + 2'h1;
         prev_q <= {op_mode, group_sel, pair_gain};
         quiet_q <= (prev_q != {op_mode, group_sel, pair_gain}) ? 32'h0 : quiet_q + 32'h1;
         dark_q <= (old && (nz & ~led_gain_red) != 4'h0) ? dark_q + 32'h1 : 32'h0;
      end
   end
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   ////////////////////////////////////////////////////////////////
   a_input_led: assert property (old && $stable(sdi_valid) |-> led_input == sdi_valid)
      else $error("input led does not follow video");
   a_ports_dir: assert property (aes_port_out == {4{$past(op_mode) == 2'b10}})
      else $error("audio port direction wrong");
   a_keep_audio: assert property (video_keep_audio == ($past(op_mode) == 2'b10))
      else $error("video audio pass wrong");
   a_mode_legal: assert property (op_mode != 2'b11)
      else $error("illegal mode");
   a_group_led: assert property (old && $stable(group_sel) |-> lit == 4'h0)
      else $error("unselected group lit");
   a_gain_led: assert property (old && $stable(pair_gain) |-> (led_gain_red & ~nz) == 4'h0)
      else $error("gain led lit at unity");
   a_gain_dark: assert property (dark_q <= BLINK_CYCLES + 2)
      else $error("gain led dark too long");
   a_stb_pulse: assert property (nv_wr_stb |=> !nv_wr_stb)
      else $error("store strobe too long");
   a_nv_hold: assert property (old && !nv_wr_stb |-> $stable({nv_wr_mode, nv_wr_group, nv_wr_gain}))
      else $error("stored value moved");
   a_commit_wait: assert property (nv_wr_stb |-> quiet_q >= COMMIT_CYCLES - 1)
      else $error("store too early");
   a_power_drop: assert property (!power_ok |=> !nv_wr_stb)
      else $error("store after power loss");
   a_apb_wait: assert property (psel && penable && !pready |=> pready ##1 !pready)
      else $error("bus answer late");
   c_store: cover property (nv_wr_stb);
   c_power: cover property (!power_ok);
   c_extract: cover property (op_mode == 2'b10);
endmodule : panel_checker

bind front_panel_control_status panel_checker #(
   .COMMIT_CYCLES(COMMIT_CYCLES), .BLINK_CYCLES(BLINK_CYCLES)) i_panel_checker (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
   .sdi_valid(sdi_valid), .led_input(led_input), .power_ok(power_ok), .nv_wr_stb(nv_wr_stb),
   .nv_wr_mode(nv_wr_mode), .nv_wr_group(nv_wr_group), .nv_wr_gain(nv_wr_gain), .op_mode(op_mode),
   .group_sel(group_sel), .pair_gain(pair_gain), .aes_port_out(aes_port_out),
   .video_keep_audio(video_keep_audio), .led_group_green(led_group_green),
   .led_group_red(led_group_red), .led_gain_red(led_gain_red));
`default_nettype wire

// ---- testbench/panel_model.sv ----
// Push-button side of the front panel.
// Assumes press is called from the bench and buttons are debounced.
`timescale 1ns/1ps
`default_nettype none
module panel_model (
   // Clock.
   input wire logic pclk,
   // Buttons, high while pressed.
   output logic btn_edit,
   output logic btn_right,
   output logic btn_left
);
   logic [2:0] btn_q = 3'h0;
   assign {btn_left, btn_right, btn_edit} = btn_q;
   // A release of two edges keeps back-to-back presses distinct.
   task automatic press(input int unsigned b);
      @(posedge pclk);
      btn_q[b] <= 1'b1;
      repeat (2) @(posedge pclk);
      btn_q[b] <= 1'b0;
      repeat (2) @(posedge pclk);
   endtask : press
endmodule : panel_model
`default_nettype wire

// ---- testbench/tb.sv ----
// Self-checking bench for the front-panel block.
// Assumes a short commit count so the stored-value timer fits the run.
`timescale 1ns/1ps
`default_nettype none
module tb;
   localparam int CC = 50;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, sdi_valid = 0, power_ok = 1;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, pair_gain, nv_wr_gain, nv_rd_gain = 32'h0000_0300;
   logic pready, pslverr, btn_edit, btn_right, btn_left, nv_wr_stb, led_input, led_mode_embed;
   logic led_mode_extract, video_keep_audio, ref_is_18;
   logic [3:0] group_audio = 0, led_group_green, led_group_red, led_vu_red, led_vu_green;
   logic [3:0] led_gain_red, aes_port_out;
   logic [1:0] op_mode, group_sel, nv_wr_mode, nv_wr_group, nv_rd_mode = 2'h2, nv_rd_group = 2'h2;
   logic [2:0] headroom_sel;
   logic [9:0] audio_delay_ms;
   logic [3:0][23:0] pair_peak = 0;
   logic [39:0] mt [7] = '{40'hb4_400000_f0, 40'hb4_200000_ff, 40'hb4_100000_0f, 40'ha4_100000_ff,
      40'ha4_010000_00, 40'h04_400000_ff, 40'h04_800000_f0};
   int n_fail = 0, comparisons = 0, n_stb = 0, k, n0;
   front_panel_control_status #(.COMMIT_CYCLES(CC), .BLINK_CYCLES(4)) i_front_panel_control_status (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .btn_edit(btn_edit),
      .btn_right(btn_right), .btn_left(btn_left), .sdi_valid(sdi_valid), .group_audio(group_audio),
      .pair_peak(pair_peak), .power_ok(power_ok), .nv_rd_mode(nv_rd_mode), .nv_rd_group(nv_rd_group),
      .nv_rd_gain(nv_rd_gain), .nv_wr_stb(nv_wr_stb), .nv_wr_mode(nv_wr_mode),
      .nv_wr_group(nv_wr_group), .nv_wr_gain(nv_wr_gain), .led_input(led_input),
      .led_mode_embed(led_mode_embed), .led_mode_extract(led_mode_extract),
      .led_group_green(led_group_green), .led_group_red(led_group_red), .led_vu_red(led_vu_red),
      .led_vu_green(led_vu_green), .led_gain_red(led_gain_red), .aes_port_out(aes_port_out),
      .video_keep_audio(video_keep_audio), .op_mode(op_mode), .group_sel(group_sel),
      .pair_gain(pair_gain), .ref_is_18(ref_is_18), .headroom_sel(headroom_sel),
      .audio_delay_ms(audio_delay_ms));
   panel_model i_panel_model (.pclk(pclk), .btn_edit(btn_edit), .btn_right(btn_right), .btn_left(btn_left));
   initial begin
      forever #10 pclk = ~pclk;
   end
   always @(posedge pclk) if (nv_wr_stb === 1'b1) begin
      n_stb++;
      {nv_rd_mode, nv_rd_group, nv_rd_gain} <= {nv_wr_mode, nv_wr_group, nv_wr_gain};
   end
   ////////////////////////////////////////////////////////////////
   task automatic end_sim;
      if (n_fail == 0 && comparisons > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : end_sim
   task automatic chk(input logic [39:0] got, input logic [39:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic w(input int n);
      repeat (n) @(posedge pclk);
      #1;
   endtask : w
   // Reads compare error flag and data together; writes ignore the answer.
   task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [32:0] exp);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      if (!wr) chk({pslverr, prdata}, exp);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : bus
   initial begin
      repeat (20000) @(posedge pclk);
      n_fail++;
      end_sim();
   end
   ////////////////////////////////////////////////////////////////
   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      w(4);
      chk(op_mode, 2);
      chk(aes_port_out, 4'hf);
      chk(video_keep_audio, 1);
      chk(led_gain_red, 4'h2);
      bus(0, 12'h000, 0, 33'h0_0000_000a);
      bus(0, 12'h010, 0, 33'h1_0000_0000);
      bus(1, 12'h004, 32'd2000, 0);
      bus(0, 12'h004, 0, 33'd1000);
      bus(1, 12'h008, 32'h0000_00f6, 0);
      bus(1, 12'h000, 32'h0000_00f4, 0);
      bus(0, 12'h000, 0, 33'h0_0000_00b4);
      chk(aes_port_out, 0);
      chk({ref_is_18, headroom_sel, audio_delay_ms}, {1'b1, 3'h5, 10'h3e8});
      w(CC + 10);
      chk({nv_wr_mode, nv_wr_group, nv_wr_gain}, 36'h1_0000_00f6);
      for (int i = 0; i < 7; i++) begin
         bus(1, 12'h000, {24'h0, mt[i][39:32]}, 0);
         @(posedge pclk);
         pair_peak <= {4{mt[i][31:8]}};
         w(4);
         chk({led_vu_red, led_vu_green}, mt[i][7:0]);
      end
      w(CC + 10);
      @(posedge pclk);
      sdi_valid <= 1'b1;
      group_audio <= 4'b0010;
      w(3);
      chk({led_input, led_group_green, led_group_red}, 9'h120);
      @(posedge pclk);
      sdi_valid <= 1'b0;
      group_audio <= 4'b1101;
      w(3);
      chk({led_input, led_group_green, led_group_red}, 9'h002);
      chk({led_mode_embed, led_mode_extract, led_gain_red}, 6'h21);
      i_panel_model.press(0);
      bus(0, 12'h00c, 0, 33'h108);
      i_panel_model.press(0);
      bus(0, 12'h00c, 0, 33'h110);
      i_panel_model.press(0);
      i_panel_model.press(1);
      bus(0, 12'h00c, 0, 33'h158);
      i_panel_model.press(0);
      i_panel_model.press(1);
      w(1);
      chk(pair_gain, 32'h0000_01f6);
      i_panel_model.press(2);
      w(1);
      chk(pair_gain, 32'h0000_00f6);
      i_panel_model.press(0);
      bus(0, 12'h00c, 0, 33'h144);
      w(CC + 10);
      i_panel_model.press(0);
      i_panel_model.press(1);
      chk(op_mode, 1);
      w(15);
      i_panel_model.press(1);
      k = 0;
      while (nv_wr_stb !== 1'b1 && k < 100) begin
         w(1);
         k++;
      end
      chk(k inside {CC - 3, CC - 2}, 1);
      chk(nv_wr_mode, 2);
      i_panel_model.press(2);
      w(10);
      @(posedge pclk);
      power_ok <= 1'b0;
      @(posedge pclk);
      power_ok <= 1'b1;
      n0 = n_stb;
      w(CC + 20);
      chk(n_stb - n0, 0);
      @(posedge pclk);
      presetn <= 1'b0;
      w(3);
      @(posedge pclk);
      presetn <= 1'b1;
      w(4);
      chk({op_mode, group_sel, pair_gain}, 36'h9_0000_00f6);
      end_sim();
   end
endmodule : tb
`default_nettype wire
